// [hw/sef_status.sv]
// Purpose: transition filters, event latches, enable masks and summaries for four status groups
// Assumes: all inputs come from logic on ref_clk; host commands arrive already parsed to binary
// Notes: event query is destructive; a new edge in the same cycle survives the clear
`timescale 1ns/100ps

// Behaviour
// - operation mask: bits 10,9,6,5,1,0
// - arm mask: only bit 1
// - sequence mask: bits 1 and 2
// - filter write loads weight sum masked to valid bits
// - query returns register bits as word
// - rising filter bit latches 0-to-1 change
// - overflow when reading exceeds range limit
// - limit one: below low, above high
// - limit two: below low, above high
// - ready after reading taken and processed
// - has-data when buffer holds two readings
// - half-full bit 8, full bit 9
// - pretrigger event raises bit 11
// - only unmasked events feed next summary
// - falling filter latches 1-to-0 change
// - idle condition raised entering idle state
module sef_status (
  input wire logic ref_clk,
  input wire logic reset,
  input wire sef_pkg::sef_cmd_t cmd,
  input wire sef_pkg::sef_meas_in_t meas_in,
  input wire logic [15:0] oper_cond_in,
  input wire logic [15:0] seq_cond_in,
  output sef_pkg::sef_rsp_t rsp,
  output logic meas_summary,
  output logic oper_summary,
  output logic arm_summary,
  output logic seq_summary
);
  import sef_pkg::*;

  typedef struct packed {
    logic [GRP_N-1:0][15:0] cond;
    logic [GRP_N-1:0][15:0] rising;
    logic [GRP_N-1:0][15:0] falling;
    logic [GRP_N-1:0][15:0] mask;
    logic [GRP_N-1:0][15:0] evt;
    logic signed [READING_W-1:0] reading;
    logic have_reading;
    logic ready;
    logic [GRP_N-1:0] summary;
    sef_rsp_t rsp;
  } sef_state_t;

  sef_state_t st;
  sef_state_t next_st;
  logic [15:0] rd_word;
  logic [GRP_N-1:0] sum_expect;

  function automatic logic [15:0] valid_mask(input logic [1:0] g);
    logic [15:0] m;
    m = 16'h0000;
    case (g)
      GRP_MEAS: m = MEAS_VALID;
      GRP_OPER: m = OPER_VALID;
      GRP_ARM: m = ARM_VALID;
      GRP_SEQ: m = SEQ_VALID;
      default: m = 16'h0000;
    endcase
    return m;
  endfunction

  // query mux, also watched by the checks below
  always_comb begin
    case (cmd.field)
      FLD_RISING: rd_word = st.rising[cmd.group];
      FLD_FALLING: rd_word = st.falling[cmd.group];
      FLD_MASK: rd_word = st.mask[cmd.group];
      FLD_EVENT: rd_word = st.evt[cmd.group];
      default: rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    for (int g = 0; g < GRP_N; g++) begin
      sum_expect[g] = |(st.evt[g] & st.mask[g]);
    end
  end

  always_comb begin
    logic [15:0] mc;
    logic [15:0] oc;
    logic [15:0] ac;
    logic [15:0] set_bits;
    logic [1:0] gi;
    mc = 16'h0000;
    oc = 16'h0000;
    ac = 16'h0000;
    set_bits = 16'h0000;
    gi = 2'h0;
    next_st = st;
    next_st.rsp = '0;

    if (meas_in.reading_strobe) begin
      next_st.reading = meas_in.reading;
      next_st.have_reading = 1'b1;
      next_st.ready = 1'b0;
    end
    if (meas_in.reading_processed) begin
      next_st.ready = 1'b1;
    end

    // conditions come from the held reading, so they lag the strobe by one cycle
    if (st.have_reading) begin
      mc[MEAS_OVERFLOW_BIT] = (st.reading > meas_in.range_max) || (st.reading < -meas_in.range_max);
      mc[MEAS_BELOW_LOW_ONE_BIT] = st.reading < meas_in.low_limit_one;
      mc[MEAS_ABOVE_HIGH_ONE_BIT] = st.reading > meas_in.high_limit_one;
      mc[MEAS_BELOW_LOW_TWO_BIT] = st.reading < meas_in.low_limit_two;
      mc[MEAS_ABOVE_HIGH_TWO_BIT] = st.reading > meas_in.high_limit_two;
    end
    mc[MEAS_READY_BIT] = st.ready;
    mc[MEAS_HAS_DATA_BIT] = meas_in.buffer_count >= MIN_BUFFER_READINGS;
    mc[MEAS_HALF_BIT] = (meas_in.buffer_size != 16'h0000)
      && ({meas_in.buffer_count, 1'b0} >= {1'b0, meas_in.buffer_size});
    mc[MEAS_FULL_BIT] = (meas_in.buffer_size != 16'h0000)
      && (meas_in.buffer_count >= meas_in.buffer_size);
    mc[MEAS_PRETRIG_BIT] = meas_in.buffer_pretrigger;

    oc = oper_cond_in;
    oc[OPER_WAIT_ARM_BIT] = st.summary[GRP_ARM];
    ac[ARM_SEQ_ONE_BIT] = st.summary[GRP_SEQ];

    next_st.cond[GRP_MEAS] = mc & MEAS_VALID;
    next_st.cond[GRP_OPER] = oc & OPER_VALID;
    next_st.cond[GRP_ARM] = ac & ARM_VALID;
    next_st.cond[GRP_SEQ] = seq_cond_in & SEQ_VALID;

    for (int g = 0; g < GRP_N; g++) begin
      gi = 2'(g);
      set_bits = (next_st.cond[g] & ~st.cond[g] & st.rising[g])
        | (~next_st.cond[g] & st.cond[g] & st.falling[g]);
      next_st.evt[g] = st.evt[g] | set_bits;
      // a destructive query keeps only edges caught this cycle
      if (cmd.valid && !cmd.write && cmd.field == FLD_EVENT && cmd.group == gi) begin
        next_st.evt[g] = set_bits;
      end
      next_st.summary[g] = |(st.evt[g] & st.mask[g]);
    end

    if (cmd.valid && cmd.write) begin
      case (cmd.field)
        FLD_RISING: next_st.rising[cmd.group] = cmd.data & valid_mask(cmd.group);
        FLD_FALLING: next_st.falling[cmd.group] = cmd.data & valid_mask(cmd.group);
        FLD_MASK: next_st.mask[cmd.group] = cmd.data & valid_mask(cmd.group);
        default: next_st.mask[cmd.group] = st.mask[cmd.group];
      endcase
    end else if (cmd.valid) begin
      next_st.rsp.valid = 1'b1;
      next_st.rsp.data = rd_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int g = 0; g < GRP_N; g++) begin
        st.cond[g] <= 16'h0000;
        st.rising[g] <= RISING_RESET & valid_mask(2'(g));
        st.falling[g] <= FALLING_RESET;
        st.mask[g] <= MASK_RESET;
        st.evt[g] <= EVENT_RESET;
      end
      st.reading <= '0;
      st.have_reading <= 1'b0;
      st.ready <= 1'b0;
      st.summary <= '0;
      st.rsp <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
  assign meas_summary = st.summary[GRP_MEAS];
  assign oper_summary = st.summary[GRP_OPER];
  assign arm_summary = st.summary[GRP_ARM];
  assign seq_summary = st.summary[GRP_SEQ];

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  logic [15:0] wr_expect;
  logic rise_meas0;
  logic fall_meas0;
  assign wr_expect = cmd.data & valid_mask(cmd.group);
  assign rise_meas0 = next_st.cond[GRP_MEAS][0] && !st.cond[GRP_MEAS][0] && st.rising[GRP_MEAS][0];
  assign fall_meas0 = !next_st.cond[GRP_MEAS][0] && st.cond[GRP_MEAS][0] && st.falling[GRP_MEAS][0];

  sequence rising_write_s;
    cmd.valid && cmd.write && cmd.field == FLD_RISING;
  endsequence

  sequence processed_then_quiet_s;
    meas_in.reading_processed ##1 !meas_in.reading_strobe;
  endsequence

  oper_mask_bits_a: assert property ((st.mask[GRP_OPER] & ~OPER_VALID) == 16'h0000)
    else $error("operation mask holds a reserved bit");
  arm_mask_bits_a: assert property ((st.mask[GRP_ARM] & ~ARM_VALID) == 16'h0000)
    else $error("arm mask holds a reserved bit");
  seq_mask_bits_a: assert property (cmd.valid && cmd.write && cmd.field == FLD_MASK && cmd.group == GRP_SEQ
    |=> st.mask[GRP_SEQ] == ($past(cmd.data) & SEQ_VALID))
    else $error("sequence mask load wrong");
  filter_load_a: assert property (rising_write_s |=> st.rising[$past(cmd.group)] == $past(wr_expect))
    else $error("rising filter did not load the written value");
  query_word_a: assert property (cmd.valid && !cmd.write |=> rsp.valid && rsp.data == $past(rd_word))
    else $error("query answer wrong or missing");
  rise_latch_a: assert property (rise_meas0 |=> st.evt[GRP_MEAS][0])
    else $error("rising edge not latched");
  overflow_cond_a: assert property (st.have_reading && st.reading > meas_in.range_max
    |=> st.cond[GRP_MEAS][MEAS_OVERFLOW_BIT])
    else $error("overflow condition missing");
  low_one_cond_a: assert property (st.have_reading && st.reading < meas_in.low_limit_one
    |=> st.cond[GRP_MEAS][MEAS_BELOW_LOW_ONE_BIT])
    else $error("lower limit one condition missing");
  high_two_cond_a: assert property (st.have_reading && st.reading > meas_in.high_limit_two
    |=> st.cond[GRP_MEAS][MEAS_ABOVE_HIGH_TWO_BIT])
    else $error("upper limit two condition missing");
  ready_cond_a: assert property (processed_then_quiet_s |=> st.cond[GRP_MEAS][MEAS_READY_BIT])
    else $error("reading ready condition missing");
  has_data_a: assert property (meas_in.buffer_count < MIN_BUFFER_READINGS
    |=> !st.cond[GRP_MEAS][MEAS_HAS_DATA_BIT])
    else $error("has-data raised below two readings");
  full_cond_a: assert property (meas_in.buffer_size != 16'h0000
    && meas_in.buffer_count >= meas_in.buffer_size
    |=> st.cond[GRP_MEAS][MEAS_FULL_BIT] && st.cond[GRP_MEAS][MEAS_HALF_BIT])
    else $error("buffer full condition missing");
  pretrig_cond_a: assert property (meas_in.buffer_pretrigger |=> st.cond[GRP_MEAS][MEAS_PRETRIG_BIT])
    else $error("pretrigger condition missing");
  masked_event_a: assert property ((st.evt[GRP_MEAS] & st.mask[GRP_MEAS]) == 16'h0000
    |=> !meas_summary)
    else $error("masked event reached summary");
  fall_latch_a: assert property (fall_meas0 |=> st.evt[GRP_MEAS][0])
    else $error("falling edge not latched");
  idle_cond_a: assert property (oper_cond_in[OPER_IDLE_BIT] |=> st.cond[GRP_OPER][OPER_IDLE_BIT])
    else $error("idle condition missing");
  summary_or_a: assert property (##1 st.summary == $past(sum_expect))
    else $error("summary does not follow event and mask");
  reserved_zero_a: assert property ((st.rising[GRP_MEAS] & ~MEAS_VALID) == 16'h0000
    && (st.falling[GRP_OPER] & ~OPER_VALID) == 16'h0000)
    else $error("reserved filter bit set");

endmodule

// [inc/sef_pkg.sv]
// Purpose: shared constants and types for the status enable and transition filter bank
// Assumes: the host parser turns decimal bit-weight sums into binary words and back
// Notes: group and field selects index the bank; masks hold the valid bit positions
package sef_pkg;

  localparam int unsigned WORD_W = 16;
  localparam int unsigned READING_W = 24;
  localparam int unsigned GRP_N = 4;

  // group select codes
  localparam logic [1:0] GRP_MEAS = 2'h0;
  localparam logic [1:0] GRP_OPER = 2'h1;
  localparam logic [1:0] GRP_ARM = 2'h2;
  localparam logic [1:0] GRP_SEQ = 2'h3;

  // register field select codes within a group
  localparam logic [1:0] FLD_RISING = 2'h0;
  localparam logic [1:0] FLD_FALLING = 2'h1;
  localparam logic [1:0] FLD_MASK = 2'h2;
  localparam logic [1:0] FLD_EVENT = 2'h3;

  // valid bit positions of each group
  localparam logic [15:0] MEAS_VALID = 16'h0BBF;
  localparam logic [15:0] OPER_VALID = 16'h0663;
  localparam logic [15:0] ARM_VALID = 16'h0002;
  localparam logic [15:0] SEQ_VALID = 16'h0006;

  // reset values
  localparam logic [15:0] RISING_RESET = 16'hFFFF;
  localparam logic [15:0] FALLING_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] EVENT_RESET = 16'h0000;

  // measurement group bit positions
  localparam int unsigned MEAS_OVERFLOW_BIT = 0;
  localparam int unsigned MEAS_BELOW_LOW_ONE_BIT = 1;
  localparam int unsigned MEAS_ABOVE_HIGH_ONE_BIT = 2;
  localparam int unsigned MEAS_BELOW_LOW_TWO_BIT = 3;
  localparam int unsigned MEAS_ABOVE_HIGH_TWO_BIT = 4;
  localparam int unsigned MEAS_READY_BIT = 5;
  localparam int unsigned MEAS_HAS_DATA_BIT = 7;
  localparam int unsigned MEAS_HALF_BIT = 8;
  localparam int unsigned MEAS_FULL_BIT = 9;
  localparam int unsigned MEAS_PRETRIG_BIT = 11;

  // operation and arm bit positions, minimum buffer readings
  localparam int unsigned OPER_WAIT_ARM_BIT = 6;
  localparam int unsigned OPER_IDLE_BIT = 10;
  localparam int unsigned ARM_SEQ_ONE_BIT = 1;
  localparam logic [15:0] MIN_BUFFER_READINGS = 16'h0002;

  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] group;
    logic [1:0] field;
    logic [15:0] data;
  } sef_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } sef_rsp_t;

  typedef struct packed {
    logic reading_strobe;
    logic reading_processed;
    logic signed [READING_W-1:0] reading;
    logic signed [READING_W-1:0] range_max;
    logic signed [READING_W-1:0] low_limit_one;
    logic signed [READING_W-1:0] high_limit_one;
    logic signed [READING_W-1:0] low_limit_two;
    logic signed [READING_W-1:0] high_limit_two;
    logic [15:0] buffer_count;
    logic [15:0] buffer_size;
    logic buffer_pretrigger;
  } sef_meas_in_t;

endpackage

// [verification/sef_host.sv]
// Purpose: host side model that issues parsed status commands
// Assumes: decimal text is already turned into 16-bit words
// Notes: one request per call; no overlap, so answers cannot be confused
`timescale 1ns/100ps
module sef_host (
  input wire logic ref_clk,
  output sef_pkg::sef_cmd_t cmd,
  input wire sef_pkg::sef_rsp_t rsp
);
  import sef_pkg::*;
  initial cmd = '0;
  // data is the weight sum in binary form
  task automatic send(input logic w, input logic [1:0] g, input logic [1:0] f,
                      input logic [15:0] d, output logic [15:0] q);
    q = 'x;
    cmd = '{1'b1, w, g, f, d};
    @(posedge ref_clk);
    #1 cmd = '0;
    // answer window is bounded; a lost answer leaves q unknown
    for (int n = 0; n < 3; n++) begin
      if (rsp.valid === 1'b1) begin
        q = rsp.data;
      end
      @(posedge ref_clk);
      #1;
    end
  endtask
endmodule

// [verification/sef_status_bench.sv]
// Purpose: self-checking bench for the status enable and transition filter bank
// Assumes: host model issues one command at a time
// Notes: limits are small values; event queries clear, so each stimulus is read once
`timescale 1ns/100ps
module sef_status_bench;
  import sef_pkg::*;
  typedef struct packed {
    logic [1:0] g;
    logic [1:0] f;
    logic [15:0] d;
    logic [15:0] e;
  } sef_row_t;
  logic ref_clk = 0;
  logic reset = 1;
  sef_cmd_t cmd;
  sef_rsp_t rsp;
  sef_meas_in_t mi;
  logic [15:0] oc = '0;
  logic [15:0] sc = '0;
  logic [15:0] q;
  logic [3:0] sums;
  int error_cnt = 0;
  int num_checks = 0;
  logic [15:0] vm [4] = '{MEAS_VALID, OPER_VALID, ARM_VALID, SEQ_VALID};
  sef_row_t rows [8] = '{
    '{GRP_OPER, FLD_MASK, 16'hFFFF, 16'h0663},
    '{GRP_ARM, FLD_MASK, 16'hFFFF, 16'h0002},
    '{GRP_SEQ, FLD_MASK, 16'hFFFF, 16'h0006},
    '{GRP_MEAS, FLD_RISING, 16'h0220, 16'h0220},
    '{GRP_MEAS, FLD_RISING, 16'h0000, 16'h0000},
    '{GRP_OPER, FLD_MASK, 16'h0202, 16'h0202},
    '{GRP_MEAS, FLD_FALLING, 16'hFFFF, 16'h0BBF},
    '{GRP_MEAS, FLD_EVENT, 16'hFFFF, 16'h0000}};
  sef_status i_dut (.ref_clk(ref_clk), .reset(reset), .cmd(cmd), .meas_in(mi), .oper_cond_in(oc),
    .seq_cond_in(sc), .rsp(rsp), .meas_summary(sums[3]), .oper_summary(sums[2]),
    .arm_summary(sums[1]), .seq_summary(sums[0]));
  sef_host i_host (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [1:0] g, input logic [1:0] f, input logic [15:0] d);
    logic [15:0] x;
    i_host.send(1'b1, g, f, d, x);
  endtask
  task automatic rd(input logic [1:0] g, input logic [1:0] f, input logic [15:0] e);
    i_host.send(1'b0, g, f, 16'h0000, q);
    chk(q, e);
  endtask
  // strobe a reading, optionally mark it processed a cycle later
  task automatic reading(input logic [23:0] v, input logic p);
    mi.reading = v;
    mi.reading_strobe = 1'b1;
    idle(1);
    mi.reading_strobe = 1'b0;
    mi.reading_processed = p;
    idle(1);
    mi.reading_processed = 1'b0;
    idle(4);
  endtask
  initial begin
    mi = '0;
    idle(16);
    reset = 0;
    foreach (rows[i]) begin
      wr(rows[i].g, rows[i].f, rows[i].d);
      rd(rows[i].g, rows[i].f, rows[i].e);
    end
    $display("register rows done");
    reset = 1;
    idle(2);
    reset = 0;
    for (int g = 0; g < 4; g++) begin
      rd(2'(g), FLD_RISING, vm[g]);
      rd(2'(g), FLD_FALLING, 16'h0000);
      rd(2'(g), FLD_MASK, 16'h0000);
    end
    $display("reset test done");
    mi.range_max = 24'h0003E8;
    mi.low_limit_one = 24'h000064;
    mi.high_limit_one = 24'h0001F4;
    mi.low_limit_two = 24'h0000C8;
    mi.high_limit_two = 24'h000320;
    mi.buffer_size = 16'h000A;
    reading(24'h000032, 1'b0);
    rd(GRP_MEAS, FLD_EVENT, 16'h000A);
    reading(24'h0007D0, 1'b1);
    rd(GRP_MEAS, FLD_EVENT, 16'h0035);
    wr(GRP_MEAS, FLD_FALLING, 16'h0001);
    reading(24'h000190, 1'b0);
    rd(GRP_MEAS, FLD_EVENT, 16'h0001);
    $display("limit test done");
    mi.buffer_count = 16'h0001;
    idle(4);
    rd(GRP_MEAS, FLD_EVENT, 16'h0000);
    for (int c = 0; c < 3; c++) begin
      mi.buffer_count = c == 0 ? 16'h0002 : c == 1 ? 16'h0005 : 16'h000A;
      idle(3);
    end
    rd(GRP_MEAS, FLD_EVENT, 16'h0380);
    mi.buffer_pretrigger = 1'b1;
    idle(1);
    mi.buffer_pretrigger = 1'b0;
    idle(4);
    chk(16'(sums[3]), 16'h0000);
    wr(GRP_MEAS, FLD_MASK, 16'h0800);
    idle(2);
    chk(16'(sums[3]), 16'h0001);
    rd(GRP_MEAS, FLD_EVENT, 16'h0800);
    idle(2);
    chk(16'(sums[3]), 16'h0000);
    $display("buffer and summary test done");
    wr(GRP_SEQ, FLD_MASK, 16'h0002);
    wr(GRP_ARM, FLD_MASK, 16'h0002);
    wr(GRP_OPER, FLD_MASK, 16'h0440);
    sc = 16'h0002;
    oc = 16'h0400;
    idle(8);
    chk(16'(sums), 16'h0007);
    rd(GRP_OPER, FLD_EVENT, 16'h0440);
    wr(GRP_OPER, FLD_RISING, 16'h0000);
    wr(GRP_OPER, FLD_FALLING, 16'h0400);
    oc = 16'h0000;
    idle(4);
    rd(GRP_OPER, FLD_EVENT, 16'h0400);
    $display("chain and falling test done");
    finish_test();
  end
  // about 240 cycles expected; the limit leaves wide margin
  initial begin
    #20000;
    error_cnt++;
    $display("watchdog expired at %0t", $time);
    finish_test();
  end
endmodule
